/* common/ddio_consts.svh */
// Offsets, field codes, reset values and timing figures of the I/O block
`ifndef DDIO_CONSTS_SVH
`define DDIO_CONSTS_SVH

// Widths
`define DDIO_AW 8
`define DDIO_DW 16
`define DDIO_NIN 8
`define DDIO_NOUT 5
`define DDIO_NIRQ 5

// Register indices
`define DDIO_R_OUT_STATE 8'h00
`define DDIO_R_CTRL 8'h01
`define DDIO_R_REL2_FN 8'h02
`define DDIO_R_REL3_FN 8'h03
`define DDIO_R_DLY_BASE 8'h04
`define DDIO_R_LOC_SRC 8'h08
`define DDIO_R_REM_SRC 8'h09
`define DDIO_R_TRACE_SRC 8'h0A
`define DDIO_R_TRACE_ST 8'h0B
`define DDIO_R_FILTER 8'h0C
`define DDIO_R_HYST 8'h0D
`define DDIO_R_SET_CMD 8'h0E
`define DDIO_R_IRQ_ST 8'h0F
`define DDIO_R_IRQ_MASK 8'h10
`define DDIO_R_PLC 8'h11
`define DDIO_R_FLAGS 8'h12
`define DDIO_R_IN_FN_BASE 8'h20

// Input function codes
`define DDIO_FN_RUN_STOP 5'h01
`define DDIO_FN_GEN_EN 5'h02
`define DDIO_FN_FAST_STOP 5'h03
`define DDIO_FN_FWD 5'h04
`define DDIO_FN_REV 5'h05
`define DDIO_FN_MULTISPEED 5'h0D
`define DDIO_FN_NO_ALARM 5'h12
`define DDIO_FN_PLC 5'h15
`define DDIO_FN_MAN_AUTO 5'h16
`define DDIO_FN_PROG_OFF 5'h1A
`define DDIO_FN_LOAD_USER 5'h1B
`define DDIO_FN_TMR2 5'h1D
`define DDIO_FN_TMR3 5'h1E
`define DDIO_FN_TRACE 5'h1F

// Relay output function codes
`define DDIO_REL_TIMER 6'h1D
`define DDIO_REL_TQ_POS 6'h2B
`define DDIO_REL_TQ_NEG 6'h2C

// Selector values
`define DDIO_SRC_MULTISPEED 4'h8
`define DDIO_TRIG_INPUT 4'h6
`define DDIO_TRACE_WAITING 2'h1
`define DDIO_TRACE_TRIGGERED 2'h2
`define DDIO_CMD_LOAD1 16'h0007
`define DDIO_CMD_LOAD2 16'h0008
`define DDIO_CMD_SAVE1 16'h000A
`define DDIO_CMD_SAVE2 16'h000B

// Reset values and write limits
`define DDIO_HYST_RST 16'h00C8
`define DDIO_HYST_MAX 16'h03E7

// Interrupt status bits
`define DDIO_IRQ_ALARM 0
`define DDIO_IRQ_REFUSE 1
`define DDIO_IRQ_REJECT 2
`define DDIO_IRQ_TRACE 3
`define DDIO_IRQ_LOAD 4

// Timing
`define DDIO_CLK_NS 4
`define DDIO_TICK_NS 1000000
`define DDIO_SAMPLE_NS 2000000
`define DDIO_CNT_W 20

`endif

/* common/ddio_pkg.sv */
// Types shared by the I/O function block and its helpers
package ddio_pkg;
`include "ddio_consts.svh"

    typedef struct packed {
        logic valid;
        logic [1:0] set;
    } ddio_load_type;

    typedef struct packed {
        logic run_stop_eff;
        logic gen_enable_eff;
        logic alarm_show;
        logic pid_ref_sel;
        logic multispeed_ok;
    } ddio_drive_type;

    typedef enum logic {DDIO_TMR_IDLE, DDIO_TMR_WAIT} ddio_tmr_st_type;

    typedef struct packed {
        ddio_tmr_st_type st;
        logic prev;
        logic relay;
        logic [15:0] cnt;
    } ddio_tmr_state_type;

    typedef struct packed {
        logic signed [15:0] y;
        logic pos;
        logic neg;
    } ddio_flt_state_type;

    typedef struct packed {
        logic [15:0] rdata;
        logic [4:0] dout;
        logic pw_ok;
        logic [5:0] rel2_fn;
        logic [5:0] rel3_fn;
        logic [3:0][15:0] dly;
        logic [3:0] loc_src;
        logic [3:0] rem_src;
        logic [3:0] trace_src;
        logic [1:0] trace_st;
        logic [3:0] flt_k;
        logic [15:0] hyst;
        logic [1:0] saved;
        logic [4:0] irq_st;
        logic [4:0] irq_mask;
        logic [7:0][4:0] in_fn;
        logic lu_prev;
        logic alarm_prev;
        ddio_load_type load;
        logic trace_start;
        ddio_drive_type drv;
        logic [7:0] ms_sel;
        logic [7:0] plc;
        logic [19:0] tick_cnt;
        logic [19:0] smp_cnt;
        logic tick;
        logic smp;
    } ddio_state_type;
endpackage : ddio_pkg

/* rtl/ddio_relay_timer.sv */
// On/off delay timer for one relay driven by a programmable input
`timescale 1ns/1ps
module ddio_relay_timer (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic tick,
    input wire logic enable,
    input wire logic level,
    input wire logic [15:0] on_dly,
    input wire logic [15:0] off_dly,
    // Relay
    output logic relay
);
    ddio_pkg::ddio_tmr_state_type s_r, s_nxt;
    logic [15:0] dly;

    always_comb begin
        s_nxt = s_r;
        dly = s_r.prev ? on_dly : off_dly;
        if (!enable) begin
            s_nxt.st = ddio_pkg::DDIO_TMR_IDLE;
            s_nxt.prev = level;
            s_nxt.relay = 1'b0;
            s_nxt.cnt = 16'h0000;
        end else if (level != s_r.prev) begin
            // Any change restarts the count; back to the held level means
            // nothing is pending and the relay stays as it is
            s_nxt.prev = level;
            s_nxt.cnt = 16'h0000;
            s_nxt.st = (level != s_r.relay) ? ddio_pkg::DDIO_TMR_WAIT
                                            : ddio_pkg::DDIO_TMR_IDLE;
        end else if (s_r.st == ddio_pkg::DDIO_TMR_WAIT && tick) begin
            if (s_r.cnt >= dly) begin
                s_nxt.relay = s_r.prev;
                s_nxt.st = ddio_pkg::DDIO_TMR_IDLE;
            end else begin
                s_nxt.cnt = s_r.cnt + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign relay = s_r.relay;
endmodule : ddio_relay_timer

/* rtl/ddio_top.sv */
// Programmable digital input and output functions of the drive board
//
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "ddio_consts.svh"
module ddio_top #(
    parameter int TICK_CYCLES = `DDIO_TICK_NS / `DDIO_CLK_NS,
    parameter int SAMPLE_CYCLES = `DDIO_SAMPLE_NS / `DDIO_CLK_NS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Terminals
    input wire logic [7:0] din,
    input wire logic [4:0] relay_drive,
    output logic [4:0] do_out,
    // Drive status
    input wire logic drive_enabled,
    input wire logic option_fitted,
    input wire logic signed [15:0] torque_current,
    // Parameter edit handshake
    input wire logic edit_req,
    output logic edit_grant,
    output logic edit_reject,
    // Results to drive
    output ddio_pkg::ddio_load_type load,
    output logic trace_start,
    output ddio_pkg::ddio_drive_type drive_ctl,
    output logic [7:0] multispeed_sel,
    output logic [7:0] plc_levels,
    output logic irq
);
    ddio_pkg::ddio_state_type s_r, s_nxt;

    // Per-input function masks
    logic [7:0] m_run, m_gen, m_fast, m_fwd, m_rev, m_ms, m_alarm;
    logic [7:0] m_plc, m_ma, m_off, m_lu, m_t2, m_t3, m_trace;
    logic ok_run, ok_gen, lock, lu_lvl, alarm_now, ms_ok;
    logic tmr2_en, tmr3_en, tmr2_relay, tmr3_relay, tq_pos, tq_neg;
    logic [4:0] irq_ev;
    logic [4:0] dout_nxt;
    logic load_req, load_ok;
    logic [1:0] load_set;

    genvar gi;
    generate
        for (gi = 0; gi < `DDIO_NIN; gi++) begin : g_in
            logic [4:0] fn;
            assign fn = s_r.in_fn[gi];
            assign m_run[gi] = (fn == `DDIO_FN_RUN_STOP);
            assign m_gen[gi] = (fn == `DDIO_FN_GEN_EN);
            assign m_fast[gi] = (fn == `DDIO_FN_FAST_STOP);
            assign m_fwd[gi] = (fn == `DDIO_FN_FWD);
            assign m_rev[gi] = (fn == `DDIO_FN_REV);
            assign m_ms[gi] = (fn == `DDIO_FN_MULTISPEED);
            assign m_alarm[gi] = (fn == `DDIO_FN_NO_ALARM);
            assign m_plc[gi] = (fn == `DDIO_FN_PLC);
            assign m_ma[gi] = (fn == `DDIO_FN_MAN_AUTO);
            assign m_off[gi] = (fn == `DDIO_FN_PROG_OFF);
            assign m_lu[gi] = (fn == `DDIO_FN_LOAD_USER);
            assign m_t2[gi] = (fn == `DDIO_FN_TMR2);
            assign m_t3[gi] = (fn == `DDIO_FN_TMR3);
            assign m_trace[gi] = (fn == `DDIO_FN_TRACE);
        end
    endgenerate

    // An unassigned group member counts as on
    assign ok_run = &(~(m_gen | m_fast | m_fwd | m_rev) | din);
    assign ok_gen = &(~(m_run | m_fast | m_fwd | m_rev) | din);
    assign lock = |(m_off & din);
    assign lu_lvl = |(m_lu & din);
    assign alarm_now = |(m_alarm & ~din);
    assign ms_ok = (s_r.loc_src == `DDIO_SRC_MULTISPEED) ||
                   (s_r.rem_src == `DDIO_SRC_MULTISPEED);
    assign tmr2_en = (s_r.rel2_fn == `DDIO_REL_TIMER);
    assign tmr3_en = (s_r.rel3_fn == `DDIO_REL_TIMER);

    // Edits are answered in the cycle they are asked
    assign edit_grant = edit_req && !lock && s_r.pw_ok;
    assign edit_reject = edit_req && !edit_grant;

    ddio_relay_timer u_tmr2 (
        .clk(clk),
        .rst_n(rst_n),
        .tick(s_r.tick),
        .enable(tmr2_en),
        .level(|(m_t2 & din)),
        .on_dly(s_r.dly[0]),
        .off_dly(s_r.dly[1]),
        .relay(tmr2_relay)
    );

    ddio_relay_timer u_tmr3 (
        .clk(clk),
        .rst_n(rst_n),
        .tick(s_r.tick),
        .enable(tmr3_en),
        .level(|(m_t3 & din)),
        .on_dly(s_r.dly[2]),
        .off_dly(s_r.dly[3]),
        .relay(tmr3_relay)
    );

    ddio_tq_filter u_filter (
        .clk(clk),
        .rst_n(rst_n),
        .smp(s_r.smp),
        .shift(s_r.flt_k),
        .hyst(s_r.hyst),
        .iq(torque_current),
        .pos(tq_pos),
        .neg(tq_neg)
    );

    function automatic logic relay_mux(input logic [5:0] fn,
                                       input logic tmr,
                                       input logic drv);
        logic r;
        r = drv;
        if (fn == `DDIO_REL_TIMER) begin
            r = tmr;
        end else if (fn == `DDIO_REL_TQ_POS) begin
            r = tq_pos;
        end else if (fn == `DDIO_REL_TQ_NEG) begin
            r = tq_neg;
        end
        return r;
    endfunction : relay_mux

    always_comb begin
        s_nxt = s_r;
        irq_ev = 5'h00;
        load_req = 1'b0;
        load_set = 2'h0;

        // Timebase dividers
        s_nxt.tick = 1'b0;
        s_nxt.smp = 1'b0;
        if (s_r.tick_cnt == 20'(TICK_CYCLES - 1)) begin
            s_nxt.tick_cnt = 20'h00000;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.tick_cnt = s_r.tick_cnt + 20'h00001;
        end
        if (s_r.smp_cnt == 20'(SAMPLE_CYCLES - 1)) begin
            s_nxt.smp_cnt = 20'h00000;
            s_nxt.smp = 1'b1;
        end else begin
            s_nxt.smp_cnt = s_r.smp_cnt + 20'h00001;
        end

        // Output pins; option outputs stay off without the board
        dout_nxt[0] = relay_drive[0];
        dout_nxt[1] = relay_mux(s_r.rel2_fn, tmr2_relay, relay_drive[1]);
        dout_nxt[2] = relay_mux(s_r.rel3_fn, tmr3_relay, relay_drive[2]);
        dout_nxt[4:3] = option_fitted ? relay_drive[4:3] : 2'h0;
        s_nxt.dout = dout_nxt;

        // Drive-facing levels
        s_nxt.drv.run_stop_eff = |(m_run & din) && ok_run;
        s_nxt.drv.gen_enable_eff = |(m_gen & din) && ok_gen;
        s_nxt.drv.alarm_show = alarm_now;
        s_nxt.drv.pid_ref_sel = |(m_ma & din);
        s_nxt.drv.multispeed_ok = ms_ok;
        s_nxt.ms_sel = ms_ok ? (m_ms & din) : 8'h00;
        s_nxt.plc = m_plc & din;
        s_nxt.alarm_prev = alarm_now;
        if (alarm_now && !s_r.alarm_prev) begin
            irq_ev[`DDIO_IRQ_ALARM] = 1'b1;
        end
        if (edit_reject) begin
            irq_ev[`DDIO_IRQ_REJECT] = 1'b1;
        end

        // Trace trigger
        s_nxt.trace_start = 1'b0;
        if (|(m_trace & din) && s_r.trace_src == `DDIO_TRIG_INPUT &&
            s_r.trace_st == `DDIO_TRACE_WAITING) begin
            s_nxt.trace_start = 1'b1;
            s_nxt.trace_st = `DDIO_TRACE_TRIGGERED;
            irq_ev[`DDIO_IRQ_TRACE] = 1'b1;
        end

        // User-set select edges, only for sets saved before
        s_nxt.lu_prev = lu_lvl;
        if (lu_lvl && !s_r.lu_prev && s_r.saved[0]) begin
            load_req = 1'b1;
            load_set = 2'h1;
        end else if (!lu_lvl && s_r.lu_prev && s_r.saved[1]) begin
            load_req = 1'b1;
            load_set = 2'h2;
        end

        // Register writes
        if (reg_wr) begin
            unique case (reg_addr)
                `DDIO_R_CTRL: s_nxt.pw_ok = reg_wdata[0];
                `DDIO_R_REL2_FN: s_nxt.rel2_fn = reg_wdata[5:0];
                `DDIO_R_REL3_FN: s_nxt.rel3_fn = reg_wdata[5:0];
                `DDIO_R_LOC_SRC: s_nxt.loc_src = reg_wdata[3:0];
                `DDIO_R_REM_SRC: s_nxt.rem_src = reg_wdata[3:0];
                `DDIO_R_TRACE_SRC: s_nxt.trace_src = reg_wdata[3:0];
                `DDIO_R_TRACE_ST: s_nxt.trace_st = reg_wdata[1:0];
                `DDIO_R_FILTER: s_nxt.flt_k = reg_wdata[3:0];
                `DDIO_R_HYST: begin
                    s_nxt.hyst = (reg_wdata > `DDIO_HYST_MAX) ?
                                 `DDIO_HYST_MAX : reg_wdata;
                end
                `DDIO_R_IRQ_MASK: s_nxt.irq_mask = reg_wdata[4:0];
                `DDIO_R_SET_CMD: begin
                    if (reg_wdata == `DDIO_CMD_SAVE1) begin
                        s_nxt.saved[0] = 1'b1;
                    end else if (reg_wdata == `DDIO_CMD_SAVE2) begin
                        s_nxt.saved[1] = 1'b1;
                    end else if (reg_wdata == `DDIO_CMD_LOAD1) begin
                        load_req = 1'b1;
                        load_set = 2'h1;
                    end else if (reg_wdata == `DDIO_CMD_LOAD2) begin
                        load_req = 1'b1;
                        load_set = 2'h2;
                    end
                end
                default: begin
                    if (reg_addr[7:2] == `DDIO_R_DLY_BASE >> 2) begin
                        s_nxt.dly[reg_addr[1:0]] = reg_wdata;
                    end else if (reg_addr[7:3] == `DDIO_R_IN_FN_BASE >> 3)
                    begin
                        s_nxt.in_fn[reg_addr[2:0]] = reg_wdata[4:0];
                    end
                end
            endcase
        end

        // Load pulse; a load while enabled is dropped and flagged
        load_ok = load_req && !drive_enabled;
        s_nxt.load.valid = load_ok;
        s_nxt.load.set = load_ok ? load_set : 2'h0;
        if (load_req && drive_enabled) begin
            irq_ev[`DDIO_IRQ_REFUSE] = 1'b1;
        end
        if (load_ok) begin
            irq_ev[`DDIO_IRQ_LOAD] = 1'b1;
        end

        // Register reads
        s_nxt.rdata = 16'h0000;
        if (reg_rd) begin
            unique case (reg_addr)
                `DDIO_R_OUT_STATE: s_nxt.rdata = {11'h000, s_r.dout};
                `DDIO_R_CTRL: s_nxt.rdata = {15'h0000, s_r.pw_ok};
                `DDIO_R_REL2_FN: s_nxt.rdata = {10'h000, s_r.rel2_fn};
                `DDIO_R_REL3_FN: s_nxt.rdata = {10'h000, s_r.rel3_fn};
                `DDIO_R_LOC_SRC: s_nxt.rdata = {12'h000, s_r.loc_src};
                `DDIO_R_REM_SRC: s_nxt.rdata = {12'h000, s_r.rem_src};
                `DDIO_R_TRACE_SRC: s_nxt.rdata = {12'h000, s_r.trace_src};
                `DDIO_R_TRACE_ST: s_nxt.rdata = {14'h0000, s_r.trace_st};
                `DDIO_R_FILTER: s_nxt.rdata = {12'h000, s_r.flt_k};
                `DDIO_R_HYST: s_nxt.rdata = s_r.hyst;
                `DDIO_R_SET_CMD: s_nxt.rdata = {14'h0000, s_r.saved};
                `DDIO_R_IRQ_ST: s_nxt.rdata = {11'h000, s_r.irq_st};
                `DDIO_R_IRQ_MASK: s_nxt.rdata = {11'h000, s_r.irq_mask};
                `DDIO_R_PLC: s_nxt.rdata = {8'h00, s_r.plc};
                `DDIO_R_FLAGS: s_nxt.rdata = {11'h000, s_r.drv};
                default: begin
                    if (reg_addr[7:2] == `DDIO_R_DLY_BASE >> 2) begin
                        s_nxt.rdata = s_r.dly[reg_addr[1:0]];
                    end else if (reg_addr[7:3] == `DDIO_R_IN_FN_BASE >> 3)
                    begin
                        s_nxt.rdata = {11'h000, s_r.in_fn[reg_addr[2:0]]};
                    end
                end
            endcase
        end

        // Sticky status; a same-cycle event survives the read clear
        if (reg_rd && reg_addr == `DDIO_R_IRQ_ST) begin
            s_nxt.irq_st = irq_ev;
        end else begin
            s_nxt.irq_st = s_r.irq_st | irq_ev;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
            s_r.hyst <= `DDIO_HYST_RST;
            s_r.lu_prev <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign reg_rdata = s_r.rdata;
    assign do_out = s_r.dout;
    assign load = s_r.load;
    assign trace_start = s_r.trace_start;
    assign drive_ctl = s_r.drv;
    assign multispeed_sel = s_r.ms_sel;
    assign plc_levels = s_r.plc;
    assign irq = |(s_r.irq_st & s_r.irq_mask);
endmodule : ddio_top

/* rtl/ddio_tq_filter.sv */
// First-order torque-current filter with hysteresis polarity outputs
`timescale 1ns/1ps
module ddio_tq_filter (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Sample and settings
    input wire logic smp,
    input wire logic [3:0] shift,
    input wire logic [15:0] hyst,
    input wire logic signed [15:0] iq,
    // Polarity
    output logic pos,
    output logic neg
);
    ddio_pkg::ddio_flt_state_type s_r, s_nxt;
    logic signed [16:0] diff;
    logic signed [16:0] step;
    logic signed [16:0] h;

    always_comb begin
        s_nxt = s_r;
        diff = 17'(iq) - 17'(s_r.y);
        // Shift form of the time constant avoids a divider
        step = diff >>> shift;
        h = $signed({1'b0, hyst});
        if (smp) begin
            s_nxt.y = s_r.y + step[15:0];
        end
        if (17'(s_r.y) > h) begin
            s_nxt.pos = 1'b1;
            s_nxt.neg = 1'b0;
        end else if (17'(s_r.y) < -h) begin
            s_nxt.pos = 1'b0;
            s_nxt.neg = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign pos = s_r.pos;
    assign neg = s_r.neg;
endmodule : ddio_tq_filter

/* verif/ddio_chk.sv */
// Port-level assertions for the I/O function block
`timescale 1ns/1ps
module ddio_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Watched ports
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic [4:0] relay_drive,
    input wire logic [4:0] do_out,
    input wire logic option_fitted,
    input wire logic drive_enabled,
    input wire logic edit_req,
    input wire logic edit_grant,
    input wire logic edit_reject,
    input wire ddio_pkg::ddio_load_type load,
    input wire logic trace_start
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data outside its cycle");
    chk_edit_answer: assert property (
        edit_req |-> edit_grant != edit_reject) else $error("edit answer");
    chk_opt_gate: assert property (
        $past(rst_n) && !$past(option_fitted) |-> do_out[4:3] == 2'h0)
        else $error("option outputs driven without board");
    chk_out_one: assert property (
        $past(rst_n) |-> do_out[0] == $past(relay_drive[0]))
        else $error("output 1 not following its source");
    chk_state_word: assert property (
        $past(rst_n) && $past(reg_rd) && $past(reg_addr) == 8'h00
        |-> reg_rdata == {11'h000, $past(do_out)})
        else $error("state word mismatch");
    chk_load_refuse: assert property (
        load.valid |-> !$past(drive_enabled)) else $error("load while on");
    chk_load_set: assert property (
        load.valid |-> load.set inside {2'h1, 2'h2}) else $error("bad set");
    chk_trace_once: assert property (
        trace_start |=> !trace_start) else $error("trace start repeated");
    cover property (load.valid);
    cover property (trace_start);
    cover property (edit_req && edit_reject);
endmodule : ddio_chk
bind ddio_top ddio_chk chk_u (.clk, .rst_n, .reg_addr, .reg_rd, .reg_rdata,
    .relay_drive, .do_out, .option_fitted, .drive_enabled, .edit_req,
    .edit_grant, .edit_reject, .load, .trace_start);

/* verif/ddio_field.sv */
// Field switches on the inputs and relay loads on the outputs
`timescale 1ns/1ps
module ddio_field (
    // Clock
    input wire logic clk,
    // Switch positions and terminals
    input wire logic [7:0] sw,
    output logic [7:0] din,
    input wire logic [4:0] do_out,
    output logic [4:0] lamp
);
    // Contacts settle a clock after the switch moves
    always_ff @(posedge clk) din <= sw;
    assign lamp = do_out;
endmodule : ddio_field

/* verif/tb_top.sv */
// Self-checking bench of the I/O function block
`timescale 1ns/1ps
`include "ddio_consts.svh"
module tb_top;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic [15:0] reg_rdata;
    logic [7:0] sw = 8'h00;
    logic [7:0] din;
    logic [4:0] relay_drive = 5'h00;
    logic [4:0] do_out;
    logic [4:0] lamp;
    logic drive_enabled = 1'h0;
    logic option_fitted = 1'h0;
    logic edit_req = 1'h0;
    logic edit_grant;
    logic edit_reject;
    ddio_pkg::ddio_load_type load;
    logic trace_start;
    ddio_pkg::ddio_drive_type drive_ctl;
    logic irq;
    logic [7:0] ms_sel;
    logic [7:0] plc;
    logic [15:0] tq = 16'h0000;
    logic [15:0] rv;
    int n_fail = 0;
    int comparisons = 0;
    ddio_top #(.TICK_CYCLES(8), .SAMPLE_CYCLES(16)) dut_u (.clk, .rst_n,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .din,
        .relay_drive, .do_out, .drive_enabled, .option_fitted,
        .torque_current(tq), .edit_req, .edit_grant, .edit_reject,
        .load, .trace_start, .drive_ctl, .multispeed_sel(ms_sel),
        .plc_levels(plc), .irq);
    ddio_field field_u (.clk, .sw, .din, .do_out, .lamp);
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge clk);
        reg_wr <= 1'h0;
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge clk);
        reg_rd <= 1'h0;
        #1;
        rv = reg_rdata;
    endtask : rd
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %0t got %h want %h", $time, got, exp);
        end
    endtask : cmp
    task automatic fn(input logic [7:0] i, input logic [4:0] code);
        wr(`DDIO_R_IN_FN_BASE + i, {11'h000, code});
    endtask : fn
    task automatic sets(input logic [7:0] v);
        @(posedge clk);
        sw <= v;
        repeat (3) @(posedge clk);
        #1;
    endtask : sets
    task automatic ed;
        @(posedge clk);
        edit_req <= 1'h1;
        #1;
        rv = {14'h0000, edit_grant, edit_reject};
        @(posedge clk);
        edit_req <= 1'h0;
    endtask : ed
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : idle
    // Polarity relays as {output 3, output 2}, n cycles after the change
    task automatic tqs(input logic [15:0] v, input int n);
        @(posedge clk);
        tq <= v;
        idle(n);
        rv = {14'h0000, lamp[2:1]};
    endtask : tqs
    task automatic end_of_test;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test
    initial begin
        forever #2 clk = ~clk;
    end
    // Whole sequence needs well under a thousand cycles
    initial begin
        #(4 * 20000);
        n_fail++;
        end_of_test;
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'h1;
        rd(`DDIO_R_HYST);
        cmp(rv, `DDIO_HYST_RST);
        wr(`DDIO_R_HYST, 16'h0500);
        rd(`DDIO_R_HYST);
        cmp(rv, `DDIO_HYST_MAX);
        rd(8'h40);
        cmp(rv, 16'h0000);
        $display("registers done");
        fn(8'h00, `DDIO_FN_PROG_OFF);
        wr(`DDIO_R_CTRL, 16'h0001);
        sets(8'h01);
        ed;
        cmp(rv, 16'h0001);
        sets(8'h00);
        ed;
        cmp(rv, 16'h0002);
        $display("edit lock done");
        wr(`DDIO_R_SET_CMD, `DDIO_CMD_SAVE1);
        @(posedge clk) drive_enabled <= 1'h1;
        wr(`DDIO_R_SET_CMD, `DDIO_CMD_LOAD1);
        cmp({13'h0000, load}, 16'h0000);
        @(posedge clk) drive_enabled <= 1'h0;
        wr(`DDIO_R_SET_CMD, `DDIO_CMD_LOAD1);
        cmp({13'h0000, load}, 16'h0005);
        rd(`DDIO_R_IRQ_ST);
        cmp(rv, 16'h0016);
        rd(`DDIO_R_IRQ_ST);
        cmp(rv, 16'h0000);
        $display("loads done");
        wr(`DDIO_R_REL2_FN, {10'h000, `DDIO_REL_TIMER});
        fn(8'h01, `DDIO_FN_TMR2);
        wr(`DDIO_R_DLY_BASE, 16'h0002);
        wr(`DDIO_R_DLY_BASE + 8'h01, 16'h0003);
        sets(8'h02);
        idle(7);
        cmp({15'h0000, lamp[1]}, 16'h0000);
        idle(30);
        cmp({15'h0000, lamp[1]}, 16'h0001);
        // A short dip must not release the relay
        sets(8'h00);
        sets(8'h02);
        idle(50);
        cmp({15'h0000, lamp[1]}, 16'h0001);
        sets(8'h00);
        idle(45);
        cmp({15'h0000, lamp[1]}, 16'h0000);
        wr(`DDIO_R_REL2_FN, 16'h0000);
        @(posedge clk) relay_drive <= 5'h1F;
        sets(8'h02);
        idle(40);
        cmp({11'h000, lamp}, 16'h0007);
        @(posedge clk) option_fitted <= 1'h1;
        idle(3);
        rd(`DDIO_R_OUT_STATE);
        cmp(rv, 16'h001F);
        $display("relays done");
        wr(`DDIO_R_TRACE_SRC, {12'h000, `DDIO_TRIG_INPUT});
        wr(`DDIO_R_TRACE_ST, {14'h0000, `DDIO_TRACE_WAITING});
        wr(`DDIO_R_IRQ_MASK, 16'h0008);
        fn(8'h02, `DDIO_FN_TRACE);
        sets(8'h04);
        cmp({15'h0000, irq}, 16'h0001);
        rd(`DDIO_R_TRACE_ST);
        cmp(rv, 16'h0002);
        rd(`DDIO_R_IRQ_ST);
        cmp(rv, 16'h0008);
        idle(1);
        cmp({15'h0000, irq}, 16'h0000);
        $display("trace done");
        fn(8'h03, `DDIO_FN_NO_ALARM);
        idle(3);
        cmp({15'h0000, drive_ctl.alarm_show}, 16'h0001);
        sets(8'h0C);
        cmp({15'h0000, drive_ctl.alarm_show}, 16'h0000);
        fn(8'h04, `DDIO_FN_MAN_AUTO);
        idle(3);
        cmp({15'h0000, drive_ctl.pid_ref_sel}, 16'h0000);
        sets(8'h1C);
        cmp({15'h0000, drive_ctl.pid_ref_sel}, 16'h0001);
        $display("inputs done");
        fn(8'h01, `DDIO_FN_LOAD_USER);
        rd(`DDIO_R_IRQ_ST);
        sets(8'h1E);
        rd(`DDIO_R_IRQ_ST);
        cmp(rv, 16'h0010);
        // Set 2 was never saved, so the falling edge must not load
        sets(8'h1C);
        rd(`DDIO_R_IRQ_ST);
        cmp(rv, 16'h0000);
        fn(8'h05, `DDIO_FN_PLC);
        fn(8'h06, `DDIO_FN_MULTISPEED);
        sets(8'h7C);
        cmp({plc, ms_sel}, 16'h2000);
        wr(`DDIO_R_LOC_SRC, {12'h000, `DDIO_SRC_MULTISPEED});
        idle(2);
        cmp({plc, ms_sel}, 16'h2040);
        fn(8'h07, `DDIO_FN_RUN_STOP);
        fn(8'h00, `DDIO_FN_GEN_EN);
        sets(8'hFC);
        cmp({14'h0000, drive_ctl[4:3]}, 16'h0000);
        sets(8'hFD);
        cmp({14'h0000, drive_ctl[4:3]}, 16'h0003);
        $display("controller inputs done");
        wr(`DDIO_R_REL2_FN, {10'h000, `DDIO_REL_TQ_NEG});
        wr(`DDIO_R_REL3_FN, {10'h000, `DDIO_REL_TQ_POS});
        tqs(16'h03E8, 20);
        cmp(rv, 16'h0002);
        // Inside the band the outputs hold their last state
        tqs(16'hFC1A, 20);
        cmp(rv, 16'h0002);
        tqs(16'hFC18, 20);
        cmp(rv, 16'h0001);
        // Halving filter needs three samples to cross the band
        wr(`DDIO_R_FILTER, 16'h0001);
        tqs(16'h05DC, 20);
        cmp(rv, 16'h0001);
        tqs(16'h05DC, 60);
        cmp(rv, 16'h0002);
        $display("torque done");
        end_of_test;
    end
endmodule : tb_top
